// ===== common/guard_pkg.sv
// package: register map, field layouts, modes and timing for the window protectors
package guard_pkg;
  localparam int NUM_CELLS = 16;
  localparam int NUM_PINS = 8;
  // register byte offsets
  localparam logic [7:0] OFS_VOLT_LIMITS = 8'h00; // [11:0] over, [27:16] under
  localparam logic [7:0] OFS_BAL_FINISH = 8'h04; // [11:0] balance finish level
  localparam logic [7:0] OFS_CELL_COUNT = 8'h08; // [3:0] highest cell index
  localparam logic [7:0] OFS_LOW_MASK = 8'h0c; // [7:0] mask a, [15:8] mask b
  localparam logic [7:0] OFS_VOLT_CTRL = 8'h10; // [1:0] mode, [2] trigger, [7:4] lock
  localparam logic [7:0] OFS_TEMP_LIMITS = 8'h14; // [4:0] hot, [10:8] cold
  localparam logic [7:0] OFS_PAUSE_TEMP = 8'h18; // [4:0] level, [10:8] cool-off
  localparam logic [7:0] OFS_PIN_CONFIG = 8'h1c; // 3 bits per pin
  localparam logic [7:0] OFS_TEMP_CTRL = 8'h20; // [1:0] mode, [2] trigger, [6:4] lock
  localparam logic [7:0] OFS_STATE_FLAGS = 8'h24; // [0] volt active, [1] temp active
  localparam logic [7:0] OFS_HIGH_VOLT = 8'h28; // [7:0] flags a, [15:8] flags b
  localparam logic [7:0] OFS_LOW_VOLT = 8'h2c;
  localparam logic [7:0] OFS_HOT = 8'h30;
  localparam logic [7:0] OFS_COLD = 8'h34;
  localparam logic [7:0] OFS_FREEZE = 8'h38; // [0] adc results held, [1] forced code
  // field positions
  localparam int MODE_LSB = 0;
  localparam int TRIG_BIT = 2;
  localparam int LOCK_LSB = 4;
  localparam int HI_LSB = 16;
  localparam int COLD_LSB = 8;
  localparam logic [2:0] CFG_ADC_TEMP = 3'h2; // pin setting: adc and temperature input
  localparam logic [15:0] ADC_BIST_CODE = 16'h8000;
  // timing
  localparam int CLK_MHZ = 50;
  localparam int SLOT_NS = 1000; // dwell per channel in round robin
  localparam int SLOT_CYC = (SLOT_NS * CLK_MHZ) / 1000;
  localparam int SETTLE_US = 100; // frontend_settle_time
  localparam int SETTLE_CYC = SETTLE_US * CLK_MHZ;
  localparam int BIST_CYC = 64;
  typedef enum logic [1:0] {MODE_STOP, MODE_ROBIN, MODE_SELFTEST, MODE_LOCK} guard_mode_t;
  typedef enum {G_IDLE, G_ROBIN, G_TEST, G_LOCK} guard_state_t;
  typedef struct packed {
    logic [11:0] over;
    logic [11:0] under;
    logic [11:0] finish;
    logic [3:0] top;
    logic [15:0] mask;
    logic [1:0] mode;
    logic [3:0] lock;
  } volt_cfg_t;
  typedef struct packed {
    logic [4:0] hot;
    logic [2:0] cold;
    logic [4:0] pause;
    logic [2:0] cool;
    logic [23:0] pins;
    logic [1:0] mode;
    logic [2:0] lock;
  } temp_cfg_t;
endpackage : guard_pkg

// ===== rtl/window_guards.sv
// window protectors: settings latch, channel sequencing and fault capture
// What this block does
// - cell index field is the top active channel; all lower ones are active too.
// - cells set in the two low-voltage mask registers skip under-voltage checks.
// - cell above over limit flags over-voltage; below under limit flags under-voltage.
// - voltage mode 00 stop, 01 round robin, 10 self-test, 11 single channel.
// - voltage round robin visits every cell at fixed rate; inactive results dropped.
// - voltage round robin also checks each cell against balance finish level.
// - voltage self-test withholds cell results and faults; host halts adc first.
// - voltage single-channel mode holds comparators on the locked cell.
// - voltage self-test freezes or forces 0x8000 results; updates resume after settle time.
// - voltage trigger captures limits, mode, cell count and masks.
// - guards keep running in sleep; stop only by stop command or shutdown.
// - volt active flag while running; over and under flags in two registers each.
// - balance finish hit is no fault; it only ends balancing on that cell.
// - only pins configured as adc-and-temperature are active; shared limits apply.
// - ratio below hot code flags hot; ratio above cold code flags cold.
// - without thermistor reference every temperature input flags hot and cold.
// - temperature mode 00 stop, 01 round robin, 10 self-test, 11 single pin.
// - temperature round robin cycles all pins; hot path also checks pause level.
// - temperature self-test withholds pin results and suspends detection.
// - temperature single-channel mode holds comparators on the locked pin.
// - temperature trigger captures limits, pause level, cool-off, mode, pin configs.
// - temp active flag; hot and cold flags apart; pause hit only pauses balancing.
`timescale 1ns/10ps
module window_guards #(
  parameter int SETTLE_CYCLES = guard_pkg::SETTLE_CYC
) (
  input wire logic sys_clk_in,
  input wire logic reset_n_in,
  input wire logic shutdown_in,
  input wire logic [7:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic [7:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  output logic [3:0] cell_select_out,
  output logic [11:0] over_dac_out,
  output logic [11:0] under_dac_out,
  output logic volt_test_out,
  input wire logic cell_over_in,
  input wire logic cell_under_in,
  output logic [2:0] pin_select_out,
  output logic [4:0] hot_dac_out,
  output logic [2:0] cold_dac_out,
  output logic temp_test_out,
  input wire logic pin_hot_in,
  input wire logic pin_cold_in,
  input wire logic ref_ok_in,
  output logic [15:0] balance_finish_hit_out,
  output logic [7:0] balance_pause_temp_hit_out,
  output logic adc_hold_out,
  output logic adc_force_code_out
);
  // reset release through two flops
  logic rst_s1, rst_n;
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rst_s1 <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_n <= rst_s1;
    end
  end

  // comparator and pin synchronisers; first stage read only by second
  logic [5:0] in_s1, in_s2;
  always_ff @(posedge sys_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      in_s1 <= 6'h00;
      in_s2 <= 6'h00;
    end else begin
      in_s1 <= {shutdown_in, ref_ok_in, pin_cold_in, pin_hot_in, cell_under_in, cell_over_in};
      in_s2 <= in_s1;
    end
  end
  wire over_s = in_s2[0];
  wire under_s = in_s2[1];
  wire hot_s = in_s2[2];
  wire cold_s = in_s2[3];
  wire ref_ok_s = in_s2[4];
  wire shut_s = in_s2[5];

  // software-side shadow registers
  logic [31:0] volt_limits, finish_lvl, cell_count, low_mask, volt_ctrl;
  logic [31:0] temp_limits, pause_temp, pin_config, temp_ctrl;
  logic [15:0] high_volt, low_volt;
  logic [7:0] hot_flags, cold_flags;
  logic volt_go, temp_go;
  guard_pkg::volt_cfg_t vcfg;
  guard_pkg::temp_cfg_t tcfg;

  // axi write: take address and data in either order, answer after both
  logic aw_held, w_held, bvalid;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  wire aw_take = s_axi_awvalid_in && !aw_held && !bvalid;
  wire w_take = s_axi_wvalid_in && !w_held && !bvalid;
  wire [7:0] wr_addr = aw_held ? aw_addr : s_axi_awaddr_in;
  wire [31:0] wr_data = w_held ? w_data : s_axi_wdata_in;
  wire [3:0] wr_strb = w_held ? w_strb : s_axi_wstrb_in;
  wire wr_fire = (aw_held || aw_take) && (w_held || w_take);
  assign s_axi_awready_out = !aw_held && !bvalid;
  assign s_axi_wready_out = !w_held && !bvalid;
  assign s_axi_bvalid_out = bvalid;
  assign s_axi_bresp_out = 2'h0;
  always_ff @(posedge sys_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      bvalid <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else begin
      if (aw_take && !wr_fire) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr_in;
      end else if (wr_fire) aw_held <= 1'b0;
      if (w_take && !wr_fire) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata_in;
        w_strb <= s_axi_wstrb_in;
      end else if (wr_fire) w_held <= 1'b0;
      if (wr_fire) bvalid <= 1'b1;
      else if (s_axi_bready_in) bvalid <= 1'b0;
    end
  end

  // byte-lane merge used by every settings register; the flag clears ignore the byte strobes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] s);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) if (s[i]) r[i*8 +: 8] = d[i*8 +: 8];
    return r;
  endfunction : merge

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    return {a[7:2], 2'h0} == ofs;
  endfunction : hit

  // trigger bits never stored, so they read as zero
  wire next_volt_go = wr_fire && hit(wr_addr, guard_pkg::OFS_VOLT_CTRL) && wr_strb[0]
                      && wr_data[guard_pkg::TRIG_BIT];
  wire next_temp_go = wr_fire && hit(wr_addr, guard_pkg::OFS_TEMP_CTRL) && wr_strb[0]
                      && wr_data[guard_pkg::TRIG_BIT];
  always_ff @(posedge sys_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      volt_limits <= 32'h0;
      finish_lvl <= 32'h0;
      cell_count <= 32'h0;
      low_mask <= 32'h0;
      volt_ctrl <= 32'h0;
      temp_limits <= 32'h0;
      pause_temp <= 32'h0;
      pin_config <= 32'h0;
      temp_ctrl <= 32'h0;
      volt_go <= 1'b0;
      temp_go <= 1'b0;
    end else begin
      volt_go <= next_volt_go;
      temp_go <= next_temp_go;
      if (wr_fire) begin
        if (hit(wr_addr, guard_pkg::OFS_VOLT_LIMITS))
          volt_limits <= merge(volt_limits, wr_data, wr_strb);
        if (hit(wr_addr, guard_pkg::OFS_BAL_FINISH))
          finish_lvl <= merge(finish_lvl, wr_data, wr_strb);
        if (hit(wr_addr, guard_pkg::OFS_CELL_COUNT))
          cell_count <= merge(cell_count, wr_data, wr_strb);
        if (hit(wr_addr, guard_pkg::OFS_LOW_MASK))
          low_mask <= merge(low_mask, wr_data, wr_strb);
        if (hit(wr_addr, guard_pkg::OFS_VOLT_CTRL))
          volt_ctrl <= merge(volt_ctrl, wr_data & 32'hf3, wr_strb);
        if (hit(wr_addr, guard_pkg::OFS_TEMP_LIMITS))
          temp_limits <= merge(temp_limits, wr_data, wr_strb);
        if (hit(wr_addr, guard_pkg::OFS_PAUSE_TEMP))
          pause_temp <= merge(pause_temp, wr_data, wr_strb);
        if (hit(wr_addr, guard_pkg::OFS_PIN_CONFIG))
          pin_config <= merge(pin_config, wr_data, wr_strb);
        if (hit(wr_addr, guard_pkg::OFS_TEMP_CTRL))
          temp_ctrl <= merge(temp_ctrl, wr_data & 32'h73, wr_strb);
      end
    end
  end

  // go latches settings; later edits wait for the next go; shutdown stops both
  wire [1:0] vmode_new = volt_ctrl[guard_pkg::MODE_LSB +: 2];
  wire [1:0] tmode_new = temp_ctrl[guard_pkg::MODE_LSB +: 2];
  always_ff @(posedge sys_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      vcfg <= '0;
      tcfg <= '0;
    end else begin
      if (shut_s) vcfg.mode <= guard_pkg::MODE_STOP;
      else if (volt_go) vcfg <= {volt_limits[11:0], volt_limits[guard_pkg::HI_LSB +: 12],
        finish_lvl[11:0], cell_count[3:0], low_mask[15:0], vmode_new,
        volt_ctrl[guard_pkg::LOCK_LSB +: 4]};
      if (shut_s) tcfg.mode <= guard_pkg::MODE_STOP;
      else if (temp_go) tcfg <= {temp_limits[4:0], temp_limits[guard_pkg::COLD_LSB +: 3],
        pause_temp[4:0], pause_temp[guard_pkg::COLD_LSB +: 3], pin_config[23:0], tmode_new,
        temp_ctrl[guard_pkg::LOCK_LSB +: 3]};
    end
  end

  // shared slot timer: fixed dwell regardless of active count
  logic [15:0] slot_cnt;
  wire slot_end = slot_cnt == 16'(guard_pkg::SLOT_CYC - 1);
  logic [3:0] vch;
  logic [2:0] tch;
  logic [7:0] vtest_cnt, ttest_cnt;
  wire v_robin = vcfg.mode == guard_pkg::MODE_ROBIN;
  wire v_test = vcfg.mode == guard_pkg::MODE_SELFTEST;
  wire v_lock = vcfg.mode == guard_pkg::MODE_LOCK;
  wire t_robin = tcfg.mode == guard_pkg::MODE_ROBIN;
  wire t_test = tcfg.mode == guard_pkg::MODE_SELFTEST;
  wire t_lock = tcfg.mode == guard_pkg::MODE_LOCK;
  always_ff @(posedge sys_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      slot_cnt <= 16'h0;
      vch <= 4'h0;
      tch <= 3'h0;
      vtest_cnt <= 8'h0;
      ttest_cnt <= 8'h0;
    end else begin
      slot_cnt <= slot_end ? 16'h0 : slot_cnt + 16'h1;
      if (v_lock) vch <= vcfg.lock;
      else if (slot_end) vch <= vch + 4'h1; // every cell visited
      if (t_lock) tch <= tcfg.lock;
      else if (slot_end) tch <= tch + 3'h1;
      vtest_cnt <= (v_test && vtest_cnt != 8'(guard_pkg::BIST_CYC)) ? vtest_cnt + 8'h1 :
                   (v_test ? vtest_cnt : 8'h0);
      ttest_cnt <= (t_test && ttest_cnt != 8'(guard_pkg::BIST_CYC)) ? ttest_cnt + 8'h1 :
                   (t_test ? ttest_cnt : 8'h0);
    end
  end
  assign cell_select_out = vch;
  assign pin_select_out = tch;
  assign volt_test_out = v_test && vtest_cnt != 8'(guard_pkg::BIST_CYC);
  assign temp_test_out = t_test && ttest_cnt != 8'(guard_pkg::BIST_CYC);
  // in voltage round robin, under dac alternates with finish level on the second half of each slot
  wire finish_phase = v_robin && slot_cnt >= 16'(guard_pkg::SLOT_CYC / 2);
  wire pause_phase = t_robin && slot_cnt >= 16'(guard_pkg::SLOT_CYC / 2);
  assign over_dac_out = vcfg.over; // shared over limit
  assign under_dac_out = finish_phase ? vcfg.finish : vcfg.under;
  assign hot_dac_out = pause_phase ? tcfg.pause : tcfg.hot;
  assign cold_dac_out = tcfg.cold;

  // sample at the end of each half slot, after the comparator has settled
  wire sample = slot_cnt == 16'(guard_pkg::SLOT_CYC / 2 - 1) || slot_end;
  wire cell_active = vch <= vcfg.top; // lower cells implied active
  wire v_detect = (v_robin || v_lock) && sample && cell_active;
  wire pin_active = tcfg.pins[tch*3 +: 3] == guard_pkg::CFG_ADC_TEMP;
  wire t_detect = (t_robin || t_lock) && sample && pin_active;
  wire t_hot = ref_ok_s ? hot_s : 1'b1; // ratio below hot code
  wire t_cold = ref_ok_s ? cold_s : 1'b1;
  always_ff @(posedge sys_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      high_volt <= 16'h0;
      low_volt <= 16'h0;
      hot_flags <= 8'h0;
      cold_flags <= 8'h0;
      balance_finish_hit_out <= 16'h0;
      balance_pause_temp_hit_out <= 8'h0;
    end else begin
      if (v_detect && !finish_phase && over_s) high_volt[vch] <= 1'b1;
      if (v_detect && !finish_phase && under_s && !vcfg.mask[vch])
        low_volt[vch] <= 1'b1;
      if (v_detect && finish_phase) balance_finish_hit_out[vch] <= under_s;
      if (t_detect && !pause_phase && t_hot) hot_flags[tch] <= 1'b1;
      if (t_detect && t_cold) cold_flags[tch] <= 1'b1;
      if (t_detect && pause_phase) balance_pause_temp_hit_out[tch] <= t_hot;
      // write one to clear; a hit in the same cycle is or-ed back in, so the set wins
      if (wr_fire && hit(wr_addr, guard_pkg::OFS_HIGH_VOLT))
        high_volt <= high_volt & ~wr_data[15:0] | (v_detect && !finish_phase && over_s ?
                     16'(1) << vch : 16'h0);
      if (wr_fire && hit(wr_addr, guard_pkg::OFS_LOW_VOLT))
        low_volt <= low_volt & ~wr_data[15:0] | (v_detect && !finish_phase && under_s &&
                    !vcfg.mask[vch] ? 16'(1) << vch : 16'h0);
      if (wr_fire && hit(wr_addr, guard_pkg::OFS_HOT))
        hot_flags <= hot_flags & ~wr_data[7:0] | (t_detect && !pause_phase && t_hot ?
                     8'(1) << tch : 8'h0);
      if (wr_fire && hit(wr_addr, guard_pkg::OFS_COLD))
        cold_flags <= cold_flags & ~wr_data[7:0] | (t_detect && t_cold ? 8'(1) << tch : 8'h0);
    end
  end

  // adc result freeze during voltage self-test and settle afterwards
  logic [$clog2(SETTLE_CYCLES + 1)-1:0] settle_cnt;
  always_ff @(posedge sys_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      settle_cnt <= '0;
    end else begin
      if (volt_test_out) settle_cnt <= ($bits(settle_cnt))'(SETTLE_CYCLES);
      else if (settle_cnt != '0) settle_cnt <= settle_cnt - 1'b1;
    end
  end
  assign adc_hold_out = volt_test_out || settle_cnt != '0;
  // host halts the adc before self-test; a start during it reads the forced code
  assign adc_force_code_out = adc_hold_out;

  // read path
  logic rvalid;
  logic [31:0] rdata;
  wire [7:0] ra = s_axi_araddr_in;
  wire [31:0] rd_word =
    hit(ra, guard_pkg::OFS_VOLT_LIMITS) ? volt_limits :
    hit(ra, guard_pkg::OFS_BAL_FINISH) ? finish_lvl :
    hit(ra, guard_pkg::OFS_CELL_COUNT) ? cell_count :
    hit(ra, guard_pkg::OFS_LOW_MASK) ? low_mask :
    hit(ra, guard_pkg::OFS_VOLT_CTRL) ? volt_ctrl :
    hit(ra, guard_pkg::OFS_TEMP_LIMITS) ? temp_limits :
    hit(ra, guard_pkg::OFS_PAUSE_TEMP) ? pause_temp :
    hit(ra, guard_pkg::OFS_PIN_CONFIG) ? pin_config :
    hit(ra, guard_pkg::OFS_TEMP_CTRL) ? temp_ctrl :
    hit(ra, guard_pkg::OFS_STATE_FLAGS) ? {30'h0, tcfg.mode != 2'h0, vcfg.mode != 2'h0} :
    hit(ra, guard_pkg::OFS_HIGH_VOLT) ? {16'h0, high_volt} :
    hit(ra, guard_pkg::OFS_LOW_VOLT) ? {16'h0, low_volt} :
    hit(ra, guard_pkg::OFS_HOT) ? {24'h0, hot_flags} :
    hit(ra, guard_pkg::OFS_COLD) ? {24'h0, cold_flags} :
    hit(ra, guard_pkg::OFS_FREEZE) ? {30'h0, adc_force_code_out, adc_hold_out} : 32'h0;
  wire rd_ok = ra <= guard_pkg::OFS_FREEZE;
  logic rerr;
  assign s_axi_arready_out = !rvalid;
  assign s_axi_rvalid_out = rvalid;
  assign s_axi_rdata_out = rdata;
  assign s_axi_rresp_out = rerr ? 2'h2 : 2'h0;
  always_ff @(posedge sys_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      rvalid <= 1'b0;
      rdata <= 32'h0;
      rerr <= 1'b0;
    end else if (s_axi_arvalid_in && !rvalid) begin
      rvalid <= 1'b1;
      rdata <= rd_word;
      rerr <= !rd_ok;
    end else if (s_axi_rready_in) rvalid <= 1'b0;
  end

  // checks
  go_latch_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
    volt_go && !shut_s |=> vcfg.mode == $past(vmode_new)) else $error("go not latched");
  // a write answer blocks the next write, so a trigger can never last two cycles
  trig_pulse_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
    volt_go |=> !volt_go) else $error("trigger stuck");
  lock_hold_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
    v_lock ##1 v_lock |-> cell_select_out == vcfg.lock) else $error("lock cell");
  test_quiet_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
    v_test |=> $stable(high_volt) || $past(wr_fire)) else $error("fault in test");
  mask_low_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
    v_detect && vcfg.mask[vch] && !low_volt[vch] |=> !low_volt[$past(vch)])
    else $error("masked cell flagged");
  ref_lost_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
    t_detect && !ref_ok_s |=> cold_flags[$past(tch)]) else $error("no ref flag");
  stop_shut_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
    shut_s |=> vcfg.mode == 2'h0 && tcfg.mode == 2'h0) else $error("shutdown run");
  hold_test_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
    volt_test_out |-> adc_hold_out ##1 adc_hold_out) else $error("adc not held");
endmodule : window_guards

// ===== tb/guard_comparators.sv
// analog side model: window comparators and threshold dacs, levels set by the bench
`timescale 1ns/10ps
module guard_comparators (
  input wire logic [3:0] cell_select_in,
  input wire logic [11:0] over_dac_in,
  input wire logic [11:0] under_dac_in,
  input wire logic [2:0] pin_select_in,
  input wire logic [4:0] hot_dac_in,
  input wire logic [2:0] cold_dac_in,
  input wire logic ref_ok_in,
  output logic cell_over_out,
  output logic cell_under_out,
  output logic pin_hot_out,
  output logic pin_cold_out
);
  logic [11:0] cell_level [16]; // written by the bench
  logic [4:0] pin_ratio [8];
  // comparators answer at once; the real ones are no slower than the slot dwell
  assign cell_over_out = cell_level[cell_select_in] > over_dac_in;
  assign cell_under_out = cell_level[cell_select_in] < under_dac_in;
  // a missing reference trips both temperature sides on every pin
  assign pin_hot_out = !ref_ok_in || pin_ratio[pin_select_in] < hot_dac_in;
  assign pin_cold_out = !ref_ok_in || pin_ratio[pin_select_in][4:2] > cold_dac_in;
endmodule : guard_comparators

// ===== tb/test_window_guards.sv
// self-checking bench for the window protectors
`timescale 1ns/10ps
module test_window_guards;
  logic clk, rst_n, shut, ref_ok, awv, wv, bry, arv, rry, c_ov, c_uv, p_hot, p_cold;
  logic awr, wr, bv, arr, rv, vtest, ttest, hold, force_code;
  logic [7:0] awa, ara, pause_hit;
  logic [31:0] wd, rd;
  logic [1:0] br, rr;
  logic [3:0] csel;
  logic [2:0] psel, cdac;
  logic [11:0] odac, udac;
  logic [4:0] hdac;
  logic [15:0] fin_hit;
  int failures = 0, n_tests = 0, cyc = 0;
  window_guards #(.SETTLE_CYCLES(10)) window_guards_inst (.sys_clk_in(clk), .reset_n_in(rst_n),
    .shutdown_in(shut), .s_axi_awaddr_in(awa), .s_axi_awvalid_in(awv), .s_axi_awready_out(awr),
    .s_axi_wdata_in(wd), .s_axi_wstrb_in(4'hf), .s_axi_wvalid_in(wv), .s_axi_wready_out(wr),
    .s_axi_bresp_out(br), .s_axi_bvalid_out(bv), .s_axi_bready_in(bry), .s_axi_araddr_in(ara),
    .s_axi_arvalid_in(arv), .s_axi_arready_out(arr), .s_axi_rdata_out(rd), .s_axi_rresp_out(rr),
    .s_axi_rvalid_out(rv), .s_axi_rready_in(rry), .cell_select_out(csel), .over_dac_out(odac),
    .under_dac_out(udac), .volt_test_out(vtest), .cell_over_in(c_ov), .cell_under_in(c_uv),
    .pin_select_out(psel), .hot_dac_out(hdac), .cold_dac_out(cdac), .temp_test_out(ttest),
    .pin_hot_in(p_hot), .pin_cold_in(p_cold), .ref_ok_in(ref_ok),
    .balance_finish_hit_out(fin_hit), .balance_pause_temp_hit_out(pause_hit),
    .adc_hold_out(hold), .adc_force_code_out(force_code));
  guard_comparators guard_comparators_inst (.cell_select_in(csel), .over_dac_in(odac),
    .under_dac_in(udac), .pin_select_in(psel), .hot_dac_in(hdac), .cold_dac_in(cdac),
    .ref_ok_in(ref_ok), .cell_over_out(c_ov), .cell_under_out(c_uv), .pin_hot_out(p_hot),
    .pin_cold_out(p_cold));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // hang guard: far above the few thousand cycles the scenarios need
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      report_and_stop();
    end
  end
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask : wt
  // ready is sampled at the falling edge; it cannot change before the next rising one
  // bready and rready stay high between transfers, so back-to-back calls never drive twice
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    logic da, dw, sa, sw, sb;
    logic [1:0] sr;
    da = 1'b0;
    dw = 1'b0;
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bry <= 1'b1;
    while (!(da && dw)) begin
      @(negedge clk);
      sa = awr;
      sw = wr;
      @(posedge clk);
      if (!da && sa) begin
        awv <= 1'b0;
        da = 1'b1;
      end
      if (!dw && sw) begin
        wv <= 1'b0;
        dw = 1'b1;
      end
    end
    do begin
      @(negedge clk);
      sb = bv;
      sr = br;
      @(posedge clk);
    end while (!sb);
    chk("bresp", {30'h0, sr}, 32'h0);
  endtask : axw
  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic sa, sv;
    ara <= a;
    arv <= 1'b1;
    rry <= 1'b1;
    do begin
      @(negedge clk);
      sa = arr;
      @(posedge clk);
    end while (!sa);
    arv <= 1'b0;
    do begin
      @(negedge clk);
      sv = rv;
      d = rd;
      r = rr;
      @(posedge clk);
    end while (!sv);
  endtask : axr
  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] m, exp);
    logic [31:0] d;
    logic [1:0] r;
    axr(a, d, r);
    chk(nm, d & m, exp);
    chk("rresp", {30'h0, r}, 32'h0);
  endtask : rchk
  task automatic t_volt;
    for (int i = 0; i < 16; i++) guard_comparators_inst.cell_level[i] = 12'h600;
    guard_comparators_inst.cell_level[0] = 12'h900; // over
    guard_comparators_inst.cell_level[1] = 12'h100; // under but masked
    guard_comparators_inst.cell_level[2] = 12'h100; // under
    guard_comparators_inst.cell_level[3] = 12'h480; // between under and finish level
    guard_comparators_inst.cell_level[5] = 12'h900; // above the top active cell
    axw(guard_pkg::OFS_VOLT_LIMITS, 32'h04000800);
    axw(guard_pkg::OFS_BAL_FINISH, 32'h00000500);
    axw(guard_pkg::OFS_CELL_COUNT, 32'h00000003);
    axw(guard_pkg::OFS_LOW_MASK, 32'h00000002);
    axw(guard_pkg::OFS_VOLT_CTRL, 32'h00000005);
    wt(2000);
    rchk("run", guard_pkg::OFS_STATE_FLAGS, 32'h1, 32'h1);
    rchk("trig", guard_pkg::OFS_VOLT_CTRL, 32'h4, 32'h0);
    rchk("high", guard_pkg::OFS_HIGH_VOLT, 32'hffff, 32'h0001);
    rchk("low", guard_pkg::OFS_LOW_VOLT, 32'hffff, 32'h0004);
    chk("finish", fin_hit & 16'hfffd, 32'h000c);
    // new limit without a trigger must not change the outcome
    axw(guard_pkg::OFS_VOLT_LIMITS, 32'h04000050);
    axw(guard_pkg::OFS_HIGH_VOLT, 32'h0000ffff);
    wt(1000);
    rchk("latched", guard_pkg::OFS_HIGH_VOLT, 32'hffff, 32'h0001);
    axw(guard_pkg::OFS_VOLT_CTRL, 32'h00000097); // lock on cell 9
    wt(120);
    chk("lock", csel, 32'h9);
    axw(guard_pkg::OFS_VOLT_CTRL, 32'h00000006);
    wt(5);
    chk("test", {vtest, hold, force_code}, 32'h7);
    wt(100);
    chk("resume", {hold, force_code}, 32'h0);
    axw(guard_pkg::OFS_VOLT_CTRL, 32'h00000004);
    wt(5);
    rchk("stop", guard_pkg::OFS_STATE_FLAGS, 32'h1, 32'h0);
    $display("test volt done");
  endtask : t_volt
  task automatic t_temp;
    logic [31:0] d;
    logic [1:0] r;
    for (int i = 0; i < 8; i++) guard_comparators_inst.pin_ratio[i] = 5'h0c;
    guard_comparators_inst.pin_ratio[0] = 5'h04; // hot and past pause level
    guard_comparators_inst.pin_ratio[1] = 5'h1c; // cold
    guard_comparators_inst.pin_ratio[2] = 5'h04; // hot but not a temperature pin
    axw(guard_pkg::OFS_PIN_CONFIG, 32'h00000012);
    axw(guard_pkg::OFS_TEMP_LIMITS, 32'h00000308);
    axw(guard_pkg::OFS_PAUSE_TEMP, 32'h0000000a);
    axw(guard_pkg::OFS_TEMP_CTRL, 32'h00000005);
    wt(1000);
    rchk("trun", guard_pkg::OFS_STATE_FLAGS, 32'h2, 32'h2);
    rchk("hot", guard_pkg::OFS_HOT, 32'hff, 32'h01);
    rchk("cold", guard_pkg::OFS_COLD, 32'hff, 32'h02);
    chk("pause", pause_hit, 32'h01);
    ref_ok <= 1'b0;
    axw(guard_pkg::OFS_HOT, 32'h000000ff);
    axw(guard_pkg::OFS_COLD, 32'h000000ff);
    wt(1000);
    rchk("nref_h", guard_pkg::OFS_HOT, 32'hff, 32'h03);
    rchk("nref_c", guard_pkg::OFS_COLD, 32'hff, 32'h03);
    // self-test mode must not detect even with the reference gone
    axw(guard_pkg::OFS_TEMP_CTRL, 32'h00000006);
    wt(5);
    chk("ttest", ttest, 32'h1);
    axw(guard_pkg::OFS_HOT, 32'h000000ff);
    wt(500);
    rchk("tquiet", guard_pkg::OFS_HOT, 32'hff, 32'h00);
    axw(guard_pkg::OFS_TEMP_CTRL, 32'h00000057);
    wt(120);
    chk("plock", psel, 32'h5);
    axr(8'h3c, d, r);
    chk("unmapped_resp", {30'h0, r}, 32'h2);
    chk("unmapped_data", d, 32'h0);
    shut <= 1'b1;
    wt(10);
    rchk("shut", guard_pkg::OFS_STATE_FLAGS, 32'h3, 32'h0);
    $display("test temp done");
  endtask : t_temp
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : report_and_stop
  initial begin
    rst_n = 1'b0;
    shut = 1'b0;
    ref_ok = 1'b1;
    awv = 1'b0;
    wv = 1'b0;
    bry = 1'b0;
    arv = 1'b0;
    rry = 1'b0;
    awa = 8'h00;
    ara = 8'h00;
    wd = 32'h0;
    wt(6);
    rst_n <= 1'b1;
    wt(4);
    t_volt();
    t_temp();
    report_and_stop();
  end
endmodule : test_window_guards
